// File: src/osr_top.sv
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module osr_top
  import osr_pkg::*;
#(
  parameter int PWRUP_TIMER_COUNT = PWRUP_TIMER_CYCLES,
  parameter int MONITOR_DELAY_COUNT = MONITOR_DELAY_CYCLES
) (
  input wire logic CLOCK_IN,
  input wire logic RESETN_IN,
  input wire logic [3:0] ADDR_IN,
  input wire logic [15:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [15:0] RDATA_OUT,
  input wire logic [2:0] CFG_START_GROUP_IN,
  input wire logic [4:0] CFG_PRIMARY_MODE_IN,
  input wire logic CFG_FAIL_MONITOR_EN_IN,
  input wire logic CFG_PWRUP_TIMER_EN_IN,
  input wire logic CFG_SUPPLY_DIP_EN_IN,
  input wire logic OSC_RUNNING_IN,
  input wire logic PLL_LOCK_IN,
  input wire logic SUPPLY_LOW_IN,
  output logic CORE_RESET_OUT,
  output logic CLOCK_HOLD_OUT,
  output logic SUPPLY_DIP_PULSE_OUT,
  output logic FAIL_TRAP_OUT,
  output logic [2:0] CLOCK_SELECT_OUT,
  output logic SYS_CLK_EN_OUT,
  output logic LOW_FREQ_XTAL_EN_OUT
);

  typedef enum logic [2:0] {
    ST_LOAD, ST_POR_WAIT, ST_PWRUP_WAIT, ST_MONITOR_WAIT, ST_CHECK, ST_RUN
  } osr_state_e;

  // Two-stage synchronisers for every configuration and status pin. No reset, so pins held
  // steady through reset are already settled at the first edge after it.
  localparam int SYNC_W = 14;
  logic [SYNC_W-1:0] sync1_q, sync1_d, sync2_q, sync2_d;
  always_comb begin
    sync1_d = {CFG_START_GROUP_IN, CFG_PRIMARY_MODE_IN, CFG_FAIL_MONITOR_EN_IN,
               CFG_PWRUP_TIMER_EN_IN, CFG_SUPPLY_DIP_EN_IN, OSC_RUNNING_IN,
               PLL_LOCK_IN, SUPPLY_LOW_IN};
    sync2_d = sync1_q;
  end

  always_ff @(posedge CLOCK_IN) begin
    sync1_q <= sync1_d;
    sync2_q <= sync2_d;
  end

  logic [2:0] cfg_group;
  logic [4:0] cfg_mode;
  logic cfg_monitor, cfg_pwrup, cfg_dip_en, osc_running, pll_lock, supply_low;
  assign cfg_group = sync2_q[13:11];
  assign cfg_mode = sync2_q[10:6];
  assign cfg_monitor = sync2_q[5];
  assign cfg_pwrup = sync2_q[4];
  assign cfg_dip_en = sync2_q[3];
  assign osc_running = sync2_q[2];
  assign pll_lock = sync2_q[1];
  assign supply_low = sync2_q[0];

  // Supply dip only counts while the detector is enabled
  logic dip_event;
  assign dip_event = cfg_dip_en && supply_low; // RULE15

  logic crystal_used;
  assign crystal_used = (cfg_mode >= CRYSTAL_MODE_MIN);

  // Timers: sequence delays and oscillator start-up wait
  logic seq_start, seq_done, ost_start, ost_done;
  logic [TIMER_W-1:0] seq_load;
  osr_delay_counter #(.W(TIMER_W)) u_seq_timer (
    .clk_in(CLOCK_IN),
    .rst_n_in(RESETN_IN),
    .start_in(seq_start),
    .load_in(seq_load),
    .done_out(seq_done)
  );
  osr_delay_counter #(.W(TIMER_W)) u_ost_timer (
    .clk_in(CLOCK_IN),
    .rst_n_in(RESETN_IN),
    .start_in(ost_start),
    .load_in(TIMER_W'(STARTUP_WAIT_CYCLES)),
    .done_out(ost_done)
  );

  // Register state
  logic [2:0] active_q, active_d;
  logic [2:0] request_q, request_d;
  logic [1:0] divider_q, divider_d;
  logic phase_q, phase_d;
  logic fail_q, fail_d;
  logic keep_xtal_q, keep_xtal_d;
  logic switch_q, switch_d;
  logic [1:0] cause_q, cause_d;
  logic [15:0] rdata_q, rdata_d;

  // Sequencer and output state
  osr_state_e state_q, state_d;
  logic core_reset_q, core_reset_d;
  logic clock_hold_q, clock_hold_d;
  logic dip_pulse_q, dip_pulse_d;
  logic trap_q, trap_d;
  logic clk_en_q, clk_en_d;
  logic lp_xtal_q, lp_xtal_d;
  logic [5:0] div_cnt_q, div_cnt_d;

  // Internal groups always ready; external need running, start-up wait in crystal modes, lock for the multiplier
  function automatic logic group_ready(input logic [2:0] grp, input logic xtal,
                                       input logic running, input logic ost_ok,
                                       input logic lock);
    logic ok;
    ok = 1'b1;
    if (grp != GRP_FAST_INTERNAL && grp != GRP_SLOW_INTERNAL) begin
      ok = running && (!xtal || ost_ok);
      if (grp == GRP_MULTIPLIER) begin
        ok = ok && lock;
      end
    end
    return ok;
  endfunction

  logic active_ready, request_ready;
  assign active_ready = group_ready(active_q, crystal_used, osc_running, ost_done, phase_q);
  assign request_ready = group_ready(request_q, crystal_used, osc_running, ost_done, phase_q);

  // Written zeros clear the fail flag and cause bits; hardware set wins
  logic wr_ctrl, wr_cause;
  assign wr_ctrl = WR_IN && (ADDR_IN == OSC_CONTROL_OFS);
  assign wr_cause = WR_IN && (ADDR_IN == RESET_CAUSE_OFS);

  // Sequencer next state, group loads and failure handling
  logic fail_event, switch_done, load_groups;
  always_comb begin
    state_d = state_q;
    seq_start = 1'b0;
    seq_load = '0;
    ost_start = 1'b0;
    fail_event = 1'b0;
    switch_done = 1'b0;
    load_groups = 1'b0;
    unique case (state_q)
      ST_LOAD: begin
        load_groups = 1'b1;
        ost_start = 1'b1;
        if (!cfg_monitor && !cfg_pwrup) begin
          state_d = ST_CHECK; // RULE9
        end else begin
          seq_start = 1'b1;
          seq_load = TIMER_W'(POR_DELAY_CYCLES);
          state_d = ST_POR_WAIT;
        end
      end
      ST_POR_WAIT: begin
        if (seq_done) begin
          if (cfg_pwrup) begin
            seq_start = 1'b1;
            seq_load = TIMER_W'(PWRUP_TIMER_COUNT); // RULE13
            state_d = ST_PWRUP_WAIT;
          end else if (crystal_used) begin
            seq_start = 1'b1;
            seq_load = TIMER_W'(MONITOR_DELAY_COUNT); // RULE13
            state_d = ST_MONITOR_WAIT;
          end else begin
            state_d = ST_CHECK;
          end
        end
      end
      ST_PWRUP_WAIT, ST_MONITOR_WAIT: begin
        if (seq_done) begin
          state_d = ST_CHECK;
        end
      end
      ST_CHECK: begin
        // Monitor off and source not ready: core stays frozen here
        if (active_ready) begin
          state_d = ST_RUN; // RULE12
        end else if (cfg_monitor) begin
          fail_event = 1'b1; // RULE8
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        // Run-time loss of the active source traps when the monitor is on
        if (cfg_monitor && !active_ready) begin
          fail_event = 1'b1;
        end else if (switch_q && request_ready) begin
          switch_done = 1'b1;
        end
      end
    endcase
    if (dip_event) begin
      state_d = ST_LOAD; // RULE11
    end
  end

  // Register file next values
  always_comb begin
    active_d = active_q;
    request_d = request_q;
    divider_d = divider_q;
    keep_xtal_d = keep_xtal_q;
    switch_d = switch_q;
    fail_d = fail_q;
    cause_d = cause_q;
    phase_d = pll_lock; // RULE17
    if (wr_ctrl) begin
      request_d = WDATA_IN[REQUEST_LSB +: 3]; // RULE5
      divider_d = WDATA_IN[DIVIDER_LSB +: 2];
      keep_xtal_d = WDATA_IN[KEEP_XTAL_BIT];
      switch_d = WDATA_IN[SWITCH_BIT]; // RULE19
      if (!WDATA_IN[FAIL_BIT]) begin
        fail_d = 1'b0;
      end
    end
    if (wr_cause) begin
      cause_d = cause_q & WDATA_IN[1:0];
    end
    if (switch_done) begin
      active_d = request_q; // RULE3
      // A request written in the same cycle is kept
      if (!wr_ctrl) begin
        switch_d = 1'b0; // RULE19
      end
    end
    if (fail_event) begin
      active_d = GRP_FAST_INTERNAL; // RULE4 RULE16
      fail_d = 1'b1; // RULE20
    end
    if (load_groups) begin
      active_d = cfg_group; // RULE2
      request_d = cfg_group; // RULE5
    end
    // Supply dip restarts like power-up but keeps the fail flag
    if (dip_event) begin
      divider_d = DIV_NONE;
      keep_xtal_d = 1'b0;
      switch_d = 1'b0;
      cause_d[CAUSE_DIP_BIT] = 1'b1; // RULE14
    end
  end

  // Read data and pin outputs
  always_comb begin
    rdata_d = '0;
    if (RD_IN) begin
      if (ADDR_IN == OSC_CONTROL_OFS) begin
        rdata_d[ACTIVE_LSB +: 3] = active_q; // RULE1
        rdata_d[REQUEST_LSB +: 3] = request_q;
        rdata_d[DIVIDER_LSB +: 2] = divider_q;
        rdata_d[PHASE_BIT] = phase_q; // RULE7
        rdata_d[FAIL_BIT] = fail_q;
        rdata_d[KEEP_XTAL_BIT] = keep_xtal_q;
        rdata_d[SWITCH_BIT] = switch_q;
      end else if (ADDR_IN == RESET_CAUSE_OFS) begin
        rdata_d[1:0] = cause_q;
      end
    end
    core_reset_d = (state_d != ST_CHECK) && (state_d != ST_RUN);
    clock_hold_d = (state_d == ST_CHECK); // RULE10 RULE12
    dip_pulse_d = dip_event; // RULE11
    trap_d = fail_event; // RULE8
    lp_xtal_d = keep_xtal_q || (active_q == GRP_LOW_FREQ_XTAL); // RULE18
    // Free-running prescaler; enable pulses once per divided period
    div_cnt_d = div_cnt_q + 6'h01;
    unique case (divider_q)
      DIV_NONE: clk_en_d = 1'b1; // RULE6
      DIV_BY16: clk_en_d = (div_cnt_q & DIV16_MASK) == DIV16_MASK; // RULE6
      DIV_BY64: clk_en_d = (div_cnt_q & DIV64_MASK) == DIV64_MASK; // RULE6
      default: clk_en_d = (div_cnt_q & DIV4_MASK) == DIV4_MASK;
    endcase
    if (core_reset_d || clock_hold_d) begin
      clk_en_d = 1'b0;
    end
  end

  // Sequencer state
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state_q <= ST_LOAD;
    end else begin
      state_q <= state_d;
    end
  end

  // Register file
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      active_q <= OSC_CONTROL_RESET[ACTIVE_LSB +: 3];
      request_q <= OSC_CONTROL_RESET[REQUEST_LSB +: 3];
      divider_q <= OSC_CONTROL_RESET[DIVIDER_LSB +: 2];
      phase_q <= OSC_CONTROL_RESET[PHASE_BIT];
      fail_q <= OSC_CONTROL_RESET[FAIL_BIT];
      keep_xtal_q <= OSC_CONTROL_RESET[KEEP_XTAL_BIT];
      switch_q <= OSC_CONTROL_RESET[SWITCH_BIT];
      cause_q <= RESET_CAUSE_RESET;
    end else begin
      active_q <= active_d;
      request_q <= request_d;
      divider_q <= divider_d;
      phase_q <= phase_d;
      fail_q <= fail_d;
      keep_xtal_q <= keep_xtal_d;
      switch_q <= switch_d;
      cause_q <= cause_d;
    end
  end

  // Read data and pin output flops
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rdata_q <= '0;
      core_reset_q <= 1'b1;
      clock_hold_q <= 1'b0;
      dip_pulse_q <= 1'b0;
      trap_q <= 1'b0;
      clk_en_q <= 1'b0;
      lp_xtal_q <= 1'b0;
      div_cnt_q <= '0;
    end else begin
      rdata_q <= rdata_d;
      core_reset_q <= core_reset_d;
      clock_hold_q <= clock_hold_d;
      dip_pulse_q <= dip_pulse_d;
      trap_q <= trap_d;
      clk_en_q <= clk_en_d;
      lp_xtal_q <= lp_xtal_d;
      div_cnt_q <= div_cnt_d;
    end
  end

  assign RDATA_OUT = rdata_q;
  assign CORE_RESET_OUT = core_reset_q;
  assign CLOCK_HOLD_OUT = clock_hold_q;
  assign SUPPLY_DIP_PULSE_OUT = dip_pulse_q;
  assign FAIL_TRAP_OUT = trap_q;
  assign CLOCK_SELECT_OUT = active_q;
  assign SYS_CLK_EN_OUT = clk_en_q;
  assign LOW_FREQ_XTAL_EN_OUT = lp_xtal_q;

endmodule // osr_top

// File: src/osr_pkg.sv
// How it works
// RULE1: Active group field bits 14:12 reports the running clock source encoding.
// RULE2: Power-up or supply-dip reset loads the active group from configuration.
// RULE3: A completed clock switch copies the requested group into the active group.
// RULE4: A detected clock failure forces the active group to the fast internal code.
// RULE5: Requested group bits 10:8 writable, 001 is fast internal, reset from configuration.
// RULE6: Divider select 11 divides by 64, 10 by 16, 00 passes clock undivided.
// RULE7: Bits 15, 11, 4, 2 read zero; bits 5, 3, 1, 0 hold the flags.
// RULE8: Monitor on and source not ready after timers: raise trap, go fast internal.
// RULE9: Monitor and power-up timer both off: leave reset at once on power-up.
// RULE10: Monitor off and no clock: core stays frozen until the clock starts.
// RULE11: Supply dip issues a reset pulse and reselects source from configuration.
// RULE12: After supply dip hold clock until start-up counter expires and lock reads one.
// RULE13: Apply reset delay plus timer, or 100 us monitor delay for crystal without timer.
// RULE14: Every supply-dip reset sets bit 1 of the reset cause register.
// RULE15: Supply-dip detector keeps working in Sleep and Idle whenever enabled.
// RULE16: Active group 001 means the device runs from the fast internal oscillator.
// RULE17: Phase flag follows the multiplier lock input, set on lock, cleared on loss.
// RULE18: Keep-on bit keeps the low-frequency crystal running, also during Sleep.
// RULE19: Software sets switch request; device clears it when the switch completes.
// RULE20: Clock fail flag sets on detected failure and stays until software clears it.
package osr_pkg;

  localparam logic [3:0] OSC_CONTROL_OFS = 4'h0;
  localparam logic [3:0] RESET_CAUSE_OFS = 4'h4;

  localparam int ACTIVE_LSB = 12;
  localparam int REQUEST_LSB = 8;
  localparam int DIVIDER_LSB = 6;
  localparam int PHASE_BIT = 5;
  localparam int FAIL_BIT = 3;
  localparam int KEEP_XTAL_BIT = 1;
  localparam int SWITCH_BIT = 0;
  localparam int CAUSE_POWER_BIT = 0;
  localparam int CAUSE_DIP_BIT = 1;

  localparam logic [2:0] GRP_MULTIPLIER = 3'h7;
  localparam logic [2:0] GRP_EXT_OSC = 3'h3;
  localparam logic [2:0] GRP_SLOW_INTERNAL = 3'h2;
  localparam logic [2:0] GRP_FAST_INTERNAL = 3'h1;
  localparam logic [2:0] GRP_LOW_FREQ_XTAL = 3'h0;

  localparam logic [1:0] DIV_NONE = 2'h0;
  localparam logic [1:0] DIV_BY16 = 2'h2;
  localparam logic [1:0] DIV_BY64 = 2'h3;
  localparam logic [5:0] DIV4_MASK = 6'h03;
  localparam logic [5:0] DIV16_MASK = 6'h0f;
  localparam logic [5:0] DIV64_MASK = 6'h3f;

  // Primary modes below this code are external clock or RC, the rest crystal
  localparam logic [4:0] CRYSTAL_MODE_MIN = 5'h04;

  localparam logic [15:0] OSC_CONTROL_RESET = 16'h0000;
  localparam logic [1:0] RESET_CAUSE_RESET = 2'h1;

  localparam int CLOCK_MHZ = 100;
  localparam int POR_DELAY_US = 10;
  localparam int PWRUP_TIMER_US = 64000;
  localparam int MONITOR_DELAY_US = 100;
  localparam int STARTUP_WAIT_CYCLES = 1024;
  localparam int POR_DELAY_CYCLES = POR_DELAY_US * CLOCK_MHZ;
  localparam int PWRUP_TIMER_CYCLES = PWRUP_TIMER_US * CLOCK_MHZ;
  localparam int MONITOR_DELAY_CYCLES = MONITOR_DELAY_US * CLOCK_MHZ;

  localparam int TIMER_W = 23;

endpackage

// File: src/osr_delay_counter.sv
`timescale 1ns/1ps
module osr_delay_counter #(
  parameter int W = 23
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic [W-1:0] load_in,
  output logic done_out
);

  logic [W-1:0] cnt_q, cnt_d;
  logic busy_q, busy_d;
  logic done_q, done_d;

  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    done_d = done_q;
    if (start_in) begin
      cnt_d = (load_in == '0) ? '0 : load_in - 1'b1;
      busy_d = 1'b1;
      done_d = 1'b0;
    end else if (busy_q) begin
      if (cnt_q == '0) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign done_out = done_q;

endmodule // osr_delay_counter

// File: sim/osr_checker.sv
`timescale 1ns/1ps
module osr_checker
  import osr_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic RESETN_IN,
  input wire logic [3:0] ADDR_IN,
  input wire logic [15:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [15:0] RDATA_OUT,
  input wire logic CFG_FAIL_MONITOR_EN_IN,
  input wire logic CFG_SUPPLY_DIP_EN_IN,
  input wire logic CORE_RESET_OUT,
  input wire logic CLOCK_HOLD_OUT,
  input wire logic SUPPLY_DIP_PULSE_OUT,
  input wire logic FAIL_TRAP_OUT,
  input wire logic [2:0] CLOCK_SELECT_OUT,
  input wire logic SYS_CLK_EN_OUT,
  input wire logic LOW_FREQ_XTAL_EN_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RESETN_IN);

  property p_keep;
    logic b;
    (WR_IN && ADDR_IN == OSC_CONTROL_OFS, b = WDATA_IN[KEEP_XTAL_BIT])
      |-> ##2 LOW_FREQ_XTAL_EN_OUT == (b || $past(CLOCK_SELECT_OUT) == GRP_LOW_FREQ_XTAL);
  endproperty

  chk_active_read: assert property (
    RD_IN && ADDR_IN == OSC_CONTROL_OFS |=> RDATA_OUT[14:12] == $past(CLOCK_SELECT_OUT))
    else $error("active group read differs");
  chk_unused_zero: assert property (
    RD_IN |=> (RDATA_OUT & 16'h8814) == 16'h0000)
    else $error("unused bits not zero");
  chk_trap_fast: assert property (
    FAIL_TRAP_OUT |-> ##[0:2] CLOCK_SELECT_OUT == GRP_FAST_INTERNAL)
    else $error("trap without fast select");
  chk_trap_pulse: assert property (
    FAIL_TRAP_OUT |-> CFG_FAIL_MONITOR_EN_IN ##1 !FAIL_TRAP_OUT)
    else $error("bad trap pulse");
  chk_dip_resets: assert property (
    SUPPLY_DIP_PULSE_OUT |-> CFG_SUPPLY_DIP_EN_IN ##[0:3] CORE_RESET_OUT)
    else $error("dip without reset");
  chk_hold_no_clk: assert property (
    (CORE_RESET_OUT || CLOCK_HOLD_OUT) && $past(CORE_RESET_OUT || CLOCK_HOLD_OUT)
      |-> !SYS_CLK_EN_OUT)
    else $error("clock enable while held");
  chk_fast_ready: assert property (
    (CLOCK_SELECT_OUT == GRP_FAST_INTERNAL && !CORE_RESET_OUT)[*4] |-> !CLOCK_HOLD_OUT)
    else $error("fast internal held");
  chk_keep_xtal: assert property (p_keep)
    else $error("keep bit not on output");

  cover property (FAIL_TRAP_OUT);
  cover property (SUPPLY_DIP_PULSE_OUT);
  cover property ($fell(CLOCK_HOLD_OUT));
endmodule // osr_checker

bind osr_top osr_checker u_chk (.CLOCK_IN, .RESETN_IN, .ADDR_IN, .WDATA_IN, .WR_IN, .RD_IN,
  .RDATA_OUT, .CFG_FAIL_MONITOR_EN_IN, .CFG_SUPPLY_DIP_EN_IN, .CORE_RESET_OUT,
  .CLOCK_HOLD_OUT, .SUPPLY_DIP_PULSE_OUT, .FAIL_TRAP_OUT, .CLOCK_SELECT_OUT,
  .SYS_CLK_EN_OUT, .LOW_FREQ_XTAL_EN_OUT);

// File: sim/osr_osc_model.sv
`timescale 1ns/1ps
module osr_osc_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [11:0] delay_in,
  input wire logic dip_in,
  output logic osc_running_out,
  output logic pll_lock_out,
  output logic supply_low_out
);
  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  always_comb begin
    cnt_d = (cnt_q == 12'hfff) ? cnt_q : cnt_q + 12'h001;
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) cnt_q <= 12'h000;
    else cnt_q <= cnt_d;
  end
  // Oscillator starts after delay_in cycles, lock follows 16 later
  assign osc_running_out = cnt_q >= delay_in;
  assign pll_lock_out = cnt_q >= delay_in + 12'h010;
  assign supply_low_out = dip_in;
endmodule // osr_osc_model

// File: sim/osc_select_reset_startup_test.sv
`timescale 1ns/1ps
module osc_select_reset_startup_test;
  import osr_pkg::*;
  logic clk, rstn, wr, rd, mon, tmr, dip, den, osc, lk, low, crst, hold, dpls, trap, cen, xtal;
  logic [3:0] addr;
  logic [15:0] wd, rdat, got, w;
  logic [2:0] grp, sel;
  logic [2:0] tgt [4];
  logic [4:0] mode;
  logic [11:0] dly;
  logic [7:0] rnd;
  int miscompares, n_compared, cycles, lat, n, traps;

  osr_top #(.PWRUP_TIMER_COUNT(50), .MONITOR_DELAY_COUNT(20)) u_dut (
    .CLOCK_IN(clk), .RESETN_IN(rstn), .ADDR_IN(addr), .WDATA_IN(wd), .WR_IN(wr), .RD_IN(rd),
    .RDATA_OUT(rdat), .CFG_START_GROUP_IN(grp), .CFG_PRIMARY_MODE_IN(mode),
    .CFG_FAIL_MONITOR_EN_IN(mon), .CFG_PWRUP_TIMER_EN_IN(tmr), .CFG_SUPPLY_DIP_EN_IN(den),
    .OSC_RUNNING_IN(osc), .PLL_LOCK_IN(lk), .SUPPLY_LOW_IN(low), .CORE_RESET_OUT(crst),
    .CLOCK_HOLD_OUT(hold), .SUPPLY_DIP_PULSE_OUT(dpls), .FAIL_TRAP_OUT(trap),
    .CLOCK_SELECT_OUT(sel), .SYS_CLK_EN_OUT(cen), .LOW_FREQ_XTAL_EN_OUT(xtal));
  osr_osc_model u_osc (.clk_in(clk), .rst_n_in(rstn), .delay_in(dly), .dip_in(dip),
    .osc_running_out(osc), .pll_lock_out(lk), .supply_low_out(low));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (trap === 1'b1) traps++;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  function automatic logic [15:0] exp_osc(input logic [2:0] a, input logic [15:0] v,
                                          input logic l, input logic f);
    return {1'b0, a, 1'b0, v[10:6], l, 1'b0, f, 1'b0, v[1:0]};
  endfunction
  task automatic test_done;
    if (miscompares == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string s, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [3:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    got = rdat;
    @(posedge clk);
  endtask
  task automatic boot(input logic [2:0] g, input logic [4:0] m, input logic o, input logic t,
                      input logic [11:0] d);
    rstn <= 1'b0;
    grp <= g;
    mode <= m;
    mon <= o;
    tmr <= t;
    dly <= d;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (lat = 0; lat < 2000 && crst !== 1'b0; lat++) @(negedge clk);
    @(posedge clk);
  endtask

  initial begin
    {rstn, wr, rd, dip, den} = 5'h01;
    addr = 4'h0;
    wd = 16'h0000;
    rnd = 8'h54;
    tgt = '{GRP_SLOW_INTERNAL, GRP_EXT_OSC, GRP_MULTIPLIER, GRP_FAST_INTERNAL};
    boot(GRP_FAST_INTERNAL, 5'h00, 1'b0, 1'b0, 12'h000);
    check("quick exit", 16'(lat <= 5), 16'h0001);
    repeat (30) @(posedge clk);
    rd_reg(OSC_CONTROL_OFS);
    check("osc reset", exp_osc(3'h1, 16'h0100, 1'b1, 1'b0), got);
    rd_reg(RESET_CAUSE_OFS);
    check("cause reset", {14'h0, RESET_CAUSE_RESET}, got);
    repeat (10) begin
      rnd = lfsr(rnd);
      w = {rnd[5], rnd[6:4], rnd[4], 1'b0, rnd[1:0], rnd[7:6], rnd[1], rnd[3:0], 1'b0};
      wr_reg(OSC_CONTROL_OFS, w);
      rd_reg(OSC_CONTROL_OFS);
      check("osc rw", exp_osc(3'h1, w, 1'b1, 1'b0), got);
      check("keep on", {15'h0, w[1]}, {15'h0, xtal});
    end
    wr_reg(4'h8, 16'hffff);
    rd_reg(4'h8);
    check("unmapped", 16'h0000, got);
    for (n = 0; n < 4; n++) begin
      wr_reg(OSC_CONTROL_OFS, {8'h01, 2'(n), 6'h00});
      repeat (70) @(posedge clk);
      lat = 0;
      repeat (256) begin
        @(negedge clk);
        lat += int'(cen === 1'b1);
      end
      check("divider", 16'(256 >> (2 * n)), 16'(lat));
      @(posedge clk);
    end
    for (n = 0; n < 4; n++) begin
      wr_reg(OSC_CONTROL_OFS, {5'h0, tgt[n], 8'h01});
      for (lat = 0; lat < 3000 && sel !== tgt[n]; lat++) @(negedge clk);
      @(posedge clk);
      rd_reg(OSC_CONTROL_OFS);
      check("switch", exp_osc(tgt[n], {5'h0, tgt[n], 8'h00}, 1'b1, 1'b0), got);
    end
    wr_reg(OSC_CONTROL_OFS, 16'h02c2);
    dip <= 1'b1;
    repeat (6) @(posedge clk);
    dip <= 1'b0;
    @(negedge clk);
    check("dip reset", 16'h0003, {14'h0, dpls, crst});
    for (lat = 0; lat < 100 && crst !== 1'b0; lat++) @(negedge clk);
    @(posedge clk);
    rd_reg(RESET_CAUSE_OFS);
    check("dip cause", 16'h0003, got);
    rd_reg(OSC_CONTROL_OFS);
    check("dip reload", exp_osc(3'h1, 16'h0100, 1'b1, 1'b0), got);
    den <= 1'b0;
    dip <= 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk);
    check("dip off", 16'h0000, {14'h0, dpls, crst});
    @(posedge clk);
    dip <= 1'b0;
    den <= 1'b1;
    boot(GRP_FAST_INTERNAL, 5'h00, 1'b0, 1'b1, 12'h000);
    check("timer delay", 16'(lat >= 1048 && lat <= 1062), 16'h0001);
    boot(GRP_EXT_OSC, 5'h04, 1'b1, 1'b0, 12'hbb8);
    check("monitor delay", 16'(lat >= 1018 && lat <= 1032), 16'h0001);
    repeat (20) @(posedge clk);
    rd_reg(OSC_CONTROL_OFS);
    check("fail trap", exp_osc(3'h1, 16'h0300, 1'b0, 1'b1), got);
    check("trap count", 16'h0001, 16'(traps));
    wr_reg(OSC_CONTROL_OFS, 16'h0300);
    rd_reg(OSC_CONTROL_OFS);
    check("fail clear", exp_osc(3'h1, 16'h0300, 1'b0, 1'b0), got);
    boot(GRP_EXT_OSC, 5'h04, 1'b0, 1'b0, 12'h12c);
    repeat (600) @(negedge clk);
    check("held", 16'h0002, {14'h0, hold, cen});
    for (lat = 0; lat < 1000 && hold !== 1'b0; lat++) @(negedge clk);
    check("released", 16'h0000, {15'h0, hold});
    test_done();
  end
endmodule // osc_select_reset_startup_test
